// File: include/vpic_defs.svh
`ifndef VPIC_DEFS_SVH
`define VPIC_DEFS_SVH

// ----------------------------------------------------------------
// sizes
// ----------------------------------------------------------------
`define NUM_IRQ 72
`define NUM_WORD_BITS 80
`define NUM_PRIO_REGS 18
`define ADDR_W 8

// ----------------------------------------------------------------
// register indexes, byte address is index times four
// ----------------------------------------------------------------
`define IDX_CTL1 6'h00
`define IDX_CTL2 6'h01
`define IDX_FLAG0 6'h02
`define IDX_EN0 6'h07
`define IDX_PRIO0 6'h0c
`define IDX_PEND 6'h1e
`define IDX_STAT 6'h1f
`define IDX_CORE 6'h20
`define NUM_FLAG_REGS 5

// ----------------------------------------------------------------
// field positions and masks
// ----------------------------------------------------------------
`define C1_NEST_DIS 15
`define C1_WR_MASK 16'hfffe
`define C1_OSC 1
`define C1_STK 2
`define C1_ADDR 3
`define C1_MATH 4
`define C1_DMA 5
`define C2_ALT 15
`define C2_WR_MASK 16'h801f
`define ST_LVL_LSB 5
`define CORE_HI_BIT 3
`define IRQ_IMPL_MASK 80'h00f7a7ffdffffffb7fff

// ----------------------------------------------------------------
// vector numbering and table layout
// ----------------------------------------------------------------
`define USER_VEC_BASE 7'h08
`define TABLE_FIRST_ENTRY 24'h000004
`define ALT_TABLE_OFFSET 24'h000100
`define TRAP_LVL_TOP 4'hf
`define NUM_TRAPS 5

`endif

// File: include/vpic_pkg.sv
package vpic_pkg;

  // complete controller state, registered as one word
  typedef struct packed {
    logic [79:0] flag;
    logic [79:0] en;
    logic [71:0][2:0] prio;
    logic [15:0] ctl1;
    logic [15:0] ctl2;
    logic [15:0] stat;
    logic [15:0] core;
    logic [6:0] pvec;
    logic [3:0] plvl;
    logic preq;
    logic [23:0] vaddr;
    logic [4:0] ext;
    logic rdy;
    logic err;
    logic [31:0] rdata;
  } state_type;

endpackage : vpic_pkg

// File: logic/irq_arbiter.sv
`timescale 1ns/1ps
`default_nettype none

// picks the enabled request with the highest level; ties go to the lower number
module irq_arbiter #(
  parameter int NUM = 72
) (
  // requests and their levels
  input wire logic [NUM-1:0] req,
  input wire logic [NUM-1:0][2:0] prio,
  // winner
  output logic found,
  output logic [6:0] win,
  output logic [2:0] win_lvl
);

  // ascending scan with strict compare keeps the lowest number on a tie
  always_comb begin
    win = 7'h00;
    win_lvl = 3'h0;
    for (int i = 0; i < NUM; i++) begin
      if (req[i] && (prio[i] > win_lvl)) begin
        win_lvl = prio[i];
        win = 7'(i);
      end
    end
    found = (win_lvl != 3'h0);
  end

endmodule : irq_arbiter

`default_nettype wire

// File: logic/vectored_priority_interrupt_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
`include "vpic_defs.svh"

module vectored_priority_interrupt_ctrl #(
  parameter int NUM_IRQ = `NUM_IRQ
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // request sources
  input wire logic [NUM_IRQ-1:0] irq_src,
  input wire logic [4:0] ext_pin,
  input wire logic [4:0] trap_src,
  // cpu side
  input wire logic cpu_ack,
  input wire logic cpu_return,
  input wire logic [3:0] cpu_return_level,
  output logic irq_req,
  output logic [6:0] irq_vector_num,
  output logic [3:0] irq_level,
  output logic [23:0] irq_vector_addr
);

  vpic_pkg::state_type s_q;
  vpic_pkg::state_type s_d;
  logic found;
  logic [6:0] win;
  logic [2:0] win_lvl;
  logic [5:0] idx;
  logic wr_en;
  logic [15:0] wd;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------

  // request number of each external pin
  function automatic int ext_irq(input int i);
    case (i)
      0: ext_irq = 0;
      1: ext_irq = 20;
      2: ext_irq = 29;
      3: ext_irq = 53;
      default: ext_irq = 54;
    endcase
  endfunction : ext_irq

  // first control word bit holding the status of trap vector v
  function automatic int trap_pos(input int v);
    case (v)
      1: trap_pos = `C1_OSC;
      2: trap_pos = `C1_ADDR;
      3: trap_pos = `C1_STK;
      4: trap_pos = `C1_MATH;
      default: trap_pos = `C1_DMA;
    endcase
  endfunction : trap_pos

  // table address of a vector in the selected table
  function automatic logic [23:0] vec_addr(input logic [6:0] v, input logic alt);
    vec_addr = `TABLE_FIRST_ENTRY + {16'h0000, v, 1'b0};
    if (alt) begin
      vec_addr = vec_addr + `ALT_TABLE_OFFSET;
    end
  endfunction : vec_addr

  // register read mux
  function automatic logic [15:0] rd_word(input vpic_pkg::state_type s,
                                          input logic [5:0] i);
    int k;
    k = 0;
    rd_word = 16'h0000;
    if (i == `IDX_CTL1) begin
      rd_word = s.ctl1;
    end else if (i == `IDX_CTL2) begin
      rd_word = s.ctl2;
    end else if (i >= `IDX_FLAG0 && i < `IDX_EN0) begin
      k = int'(i - `IDX_FLAG0);
      rd_word = s.flag[k*16 +: 16];
    end else if (i >= `IDX_EN0 && i < `IDX_PRIO0) begin
      k = int'(i - `IDX_EN0);
      rd_word = s.en[k*16 +: 16];
    end else if (i >= `IDX_PRIO0 && i < `IDX_PEND) begin
      k = int'(i - `IDX_PRIO0);
      for (int j = 0; j < 4; j++) begin
        rd_word[j*4 +: 3] = s.prio[k*4+j];
      end
    end else if (i == `IDX_PEND) begin
      rd_word = {4'h0, s.plvl, 1'b0, s.pvec};
    end else if (i == `IDX_STAT) begin
      rd_word = s.stat;
    end else if (i == `IDX_CORE) begin
      rd_word = s.core;
    end
  endfunction : rd_word

  // ----------------------------------------------------------------
  // arbitration over enabled user requests
  // ----------------------------------------------------------------
  irq_arbiter #(
    .NUM(NUM_IRQ)
  ) u_arb (
    .req(s_q.flag[NUM_IRQ-1:0] & s_q.en[NUM_IRQ-1:0]),
    .prio(s_q.prio),
    .found(found),
    .win(win),
    .win_lvl(win_lvl)
  );

  // bus decode
  assign idx = paddr[7:2];
  assign wr_en = psel && penable && pwrite && s_q.rdy && !s_q.err;
  assign wd = pwdata[15:0];

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    logic [3:0] cur_lvl;
    logic trap_hit;
    int k;
    s_d = s_q;
    cur_lvl = 4'h0;
    trap_hit = 1'b0;
    k = 0;

    // apb: zero wait states, answer in the first access cycle
    s_d.rdy = psel && !penable;
    s_d.err = psel && !penable && (idx > `IDX_CORE);
    s_d.rdata = {16'h0000, rd_word(s_q, idx)};

    // software writes first, so hardware sets below win over clears
    if (wr_en) begin
      if (idx == `IDX_CTL1) begin
        s_d.ctl1 = wd & `C1_WR_MASK;
      end else if (idx == `IDX_CTL2) begin
        s_d.ctl2 = wd & `C2_WR_MASK;
      end else if (idx >= `IDX_FLAG0 && idx < `IDX_EN0) begin
        k = int'(idx - `IDX_FLAG0);
        s_d.flag[k*16 +: 16] = wd;
      end else if (idx >= `IDX_EN0 && idx < `IDX_PRIO0) begin
        k = int'(idx - `IDX_EN0);
        s_d.en[k*16 +: 16] = wd;
      end else if (idx >= `IDX_PRIO0 && idx < `IDX_PEND) begin
        k = int'(idx - `IDX_PRIO0);
        for (int j = 0; j < 4; j++) begin
          s_d.prio[k*4+j] = wd[j*4 +: 3];
        end
      end else if (idx == `IDX_STAT) begin
        s_d.stat = wd;
        if (s_q.ctl1[`C1_NEST_DIS]) begin
          s_d.stat[7:5] = s_q.stat[7:5];
        end
      end else if (idx == `IDX_CORE) begin
        s_d.core = wd;
        s_d.core[`CORE_HI_BIT] = s_q.core[`CORE_HI_BIT] & wd[`CORE_HI_BIT];
      end
    end

    // hardware sets of request flags, external pins by selected edge
    s_d.flag[NUM_IRQ-1:0] = s_d.flag[NUM_IRQ-1:0] | irq_src;
    for (int i = 0; i < 5; i++) begin
      if (s_q.ctl2[i] ? (!ext_pin[i] && s_q.ext[i]) : (ext_pin[i] && !s_q.ext[i])) begin
        s_d.flag[ext_irq(i)] = 1'b1;
      end
    end
    s_d.flag = s_d.flag & `IRQ_IMPL_MASK;
    s_d.ext = ext_pin;
    for (int v = 1; v <= `NUM_TRAPS; v++) begin
      if (trap_src[v-1]) begin
        s_d.ctl1[trap_pos(v)] = 1'b1;
      end
    end

    // cpu takes the pending request or returns from a handler
    if (cpu_ack && s_q.preq) begin
      if (s_q.pvec < `USER_VEC_BASE) begin
        s_d.core[`CORE_HI_BIT] = 1'b1;
        s_d.stat[7:5] = s_q.plvl[2:0];
      end else if (s_q.ctl1[`C1_NEST_DIS]) begin
        s_d.stat[7:5] = 3'h7;
      end else begin
        s_d.stat[7:5] = s_q.plvl[2:0];
      end
    end else if (cpu_return) begin
      s_d.core[`CORE_HI_BIT] = cpu_return_level[3];
      s_d.stat[7:5] = cpu_return_level[2:0];
    end

    // pending decision against the level the cpu will hold next
    cur_lvl = {s_d.core[`CORE_HI_BIT], s_d.stat[7:5]};
    s_d.preq = 1'b0;
    s_d.pvec = 7'h00;
    s_d.plvl = 4'h0;
    for (int v = `NUM_TRAPS; v >= 1; v--) begin
      if (s_q.ctl1[trap_pos(v)] && ((`TRAP_LVL_TOP - 4'(v)) > cur_lvl)) begin
        trap_hit = 1'b1;
        s_d.pvec = 7'(v);
        s_d.plvl = `TRAP_LVL_TOP - 4'(v);
      end
    end
    if (trap_hit) begin
      s_d.preq = 1'b1;
    // a winner whose flag or enable is cleared this cycle must not stay pending
    end else if (found && s_d.flag[win] && s_d.en[win] && ({1'b0, win_lvl} > cur_lvl)) begin
      s_d.preq = 1'b1;
      s_d.pvec = win + `USER_VEC_BASE;
      s_d.plvl = {1'b0, win_lvl};
    end
    s_d.vaddr = vec_addr(s_d.pvec, s_d.ctl2[`C2_ALT]);
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // outputs straight from the state register
  assign prdata = s_q.rdata;
  assign pready = s_q.rdy;
  assign pslverr = s_q.err;
  assign irq_req = s_q.preq;
  assign irq_vector_num = s_q.pvec;
  assign irq_level = s_q.plvl;
  assign irq_vector_addr = s_q.vaddr;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  logic wr_flag;
  logic [NUM_IRQ-1:0] src_mask;
  localparam logic [79:0] IMPL_MASK = `IRQ_IMPL_MASK;
  assign wr_flag = wr_en && (idx >= `IDX_FLAG0) && (idx < `IDX_EN0);
  assign src_mask = irq_src & IMPL_MASK[NUM_IRQ-1:0];

  sequence ack_user_nested;
    cpu_ack && irq_req && (irq_vector_num >= `USER_VEC_BASE) && s_q.ctl1[`C1_NEST_DIS];
  endsequence

  chk_alt_table_addr: assert property (irq_req |-> irq_vector_addr ==
    (s_q.ctl2[`C2_ALT] ? 24'h000104 : 24'h000004) + {16'h0000, irq_vector_num, 1'b0})
    else $error("vector address does not match table and vector");
  chk_reserved_flags: assert property ((s_q.flag & ~`IRQ_IMPL_MASK) == 80'h0)
    else $error("reserved request flag is set");
  chk_flag_sticky: assert property (!wr_flag |=>
    ((s_q.flag & $past(s_q.flag)) == $past(s_q.flag)))
    else $error("request flag cleared without software write");
  chk_source_sets: assert property (|src_mask |=>
    ((s_q.flag[NUM_IRQ-1:0] & $past(src_mask)) == $past(src_mask)))
    else $error("source pulse did not set its flag");
  chk_user_pending_vector_number: assert property (irq_req && irq_vector_num >= 7'h08 |->
    s_q.flag[irq_vector_num - 7'h08] && s_q.en[irq_vector_num - 7'h08])
    else $error("pending vector not backed by flag and enable");
  chk_level_above: assert property (irq_req |->
    irq_level > {s_q.core[`CORE_HI_BIT], s_q.stat[7:5]})
    else $error("pending level not above cpu level");
  chk_level_seven: assert property (irq_req && s_q.stat[7:5] == 3'h7 |->
    irq_vector_num < 7'h08)
    else $error("user request pending at level seven");
  chk_hi_bit_no_set: assert property (wr_en && idx == `IDX_CORE && !cpu_ack &&
    !cpu_return |=> !$rose(s_q.core[`CORE_HI_BIT]))
    else $error("software set cpu priority high bit");
  chk_nest_ro: assert property (wr_en && idx == `IDX_STAT && s_q.ctl1[`C1_NEST_DIS] &&
    !cpu_ack && !cpu_return |=> $stable(s_q.stat[7:5]))
    else $error("low cpu level changed while nesting disabled");
  chk_nest_off: assert property (ack_user_nested |=> s_q.stat[7:5] == 3'h7)
    else $error("nesting not blocked after acknowledge");
  chk_apb_ready: assert property (psel && !penable |=> pready ##1 !pready)
    else $error("apb ready not one cycle after setup");

endmodule : vectored_priority_interrupt_ctrl

`default_nettype wire

// File: tb/cpu_core_model.sv
`timescale 1ns/1ps
`default_nettype none

// cpu stand-in: takes a standing request after a delay, returns from its handler later
module cpu_core_model (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // bench control
  input wire logic ack_en,
  input wire logic [3:0] ack_delay,
  input wire logic [3:0] ret_lvl,
  // controller side
  input wire logic irq_req,
  output logic cpu_ack,
  output logic cpu_return,
  output logic [3:0] cpu_return_level
);
  logic busy_q;
  logic [3:0] cnt_q;

  assign cpu_return_level = ret_lvl;

  // ack only while a request stands; handler counts on from ack_delay up to fifteen, then returns
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy_q <= 1'b0;
      cnt_q <= 4'h0;
      cpu_ack <= 1'b0;
      cpu_return <= 1'b0;
    end else begin
      cpu_ack <= 1'b0;
      cpu_return <= 1'b0;
      cnt_q <= 4'h0;
      if (busy_q) begin
        cnt_q <= cnt_q + 4'h1;
        cpu_return <= (cnt_q == 4'hf);
        busy_q <= (cnt_q != 4'hf);
      end else if (irq_req && ack_en) begin
        cnt_q <= cnt_q + 4'h1;
        cpu_ack <= (cnt_q >= ack_delay);
        busy_q <= (cnt_q >= ack_delay);
      end
    end
  end
endmodule : cpu_core_model

`default_nettype wire

// File: tb/tb_vectored_priority_interrupt_ctrl.sv
`timescale 1ns/1ps
`default_nettype none

module tb_vectored_priority_interrupt_ctrl;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, perr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [71:0] irq_src;
  logic [4:0] trap_src;
  logic [4:0] ext_pin;
  logic cpu_ack, cpu_return, irq_req, ack_en;
  logic [3:0] cpu_return_level, irq_level, ret_lvl, dly;
  logic [6:0] irq_vector_num;
  logic [23:0] irq_vector_addr;
  int errors, check_count, seed, n, p, lvl, alt, i;

  vectored_priority_interrupt_ctrl dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .irq_src(irq_src), .ext_pin(ext_pin),
    .trap_src(trap_src), .cpu_ack(cpu_ack), .cpu_return(cpu_return),
    .cpu_return_level(cpu_return_level), .irq_req(irq_req),
    .irq_vector_num(irq_vector_num), .irq_level(irq_level), .irq_vector_addr(irq_vector_addr));
  cpu_core_model cpu (.pclk(pclk), .presetn(presetn), .ack_en(ack_en), .ack_delay(dly),
    .ret_lvl(ret_lvl), .irq_req(irq_req), .cpu_ack(cpu_ack), .cpu_return(cpu_return),
    .cpu_return_level(cpu_return_level));

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic impl(input int r);
    return !(r inside {15, 18, 45, 59, 60, 62, 67});
  endfunction : impl

  function automatic logic [23:0] vaddr(input int v, input int a);
    return 24'h000004 + 24'(2 * v) + (a != 0 ? 24'h000100 : 24'h000000);
  endfunction : vaddr

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // one apb transfer, held until pready is seen high at an edge
  task automatic apb(input logic wr, input int idx, input logic [15:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= 8'(idx * 4);
    pwdata <= {16'h0000, d};
    @(posedge pclk);
    penable <= 1'b1;
    // only the watchdog ends a wait for ready
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    perr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rdchk(input int idx, input logic [31:0] exp);
    apb(1'b0, idx, 16'h0000);
    chk(rd, exp);
  endtask : rdchk

  // one-cycle source pulse, then time for flag and arbitration to land
  task automatic pulse(input logic [71:0] m, input logic [4:0] t);
    @(posedge pclk);
    irq_src <= m;
    trap_src <= t;
    @(posedge pclk);
    irq_src <= '0;
    trap_src <= 5'h00;
    repeat (2) @(posedge pclk);
  endtask : pulse

  task automatic take_ack();
    ack_en <= 1'b1;
    for (n = 0; n < 50 && cpu_ack !== 1'b1; n++) @(posedge pclk);
    ack_en <= 1'b0;
  endtask : take_ack

  task automatic wrap_up();
    $display("errors=%0d checks=%0d", errors, check_count);
    if (errors == 0 && check_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : wrap_up

  // ----------------------------------------------------------------
  // clock, watchdog, scenarios
  // ----------------------------------------------------------------
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end

  initial begin
    #1000000;
    errors++;
    wrap_up();
  end

  initial begin
    seed = 32'h53ad911d;
    {presetn, psel, penable, pwrite, ack_en} = 5'h00;
    paddr = 8'h00;
    pwdata = 32'h0;
    irq_src = '0;
    trap_src = 5'h00;
    ext_pin = 5'h00;
    ret_lvl = 4'h0;
    dly = 4'h2;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    for (i = 0; i < 33; i++) rdchk(i, 32'h0);
    apb(1'b0, 33, 16'h0);
    chk(perr, 1'b1);
    apb(1'b1, 1, 16'h7fe0);
    rdchk(1, 32'h0);
    apb(1'b1, 32, 16'h0008);
    rdchk(32, 32'h0);
    apb(1'b1, 31, 16'h00a0);
    rdchk(31, 32'h00a0);
    apb(1'b1, 0, 16'h8000);
    apb(1'b1, 31, 16'h0000);
    rdchk(31, 32'h00a0);
    apb(1'b1, 0, 16'h0000);
    // pin 0 set to falling edge, pin 1 left on rising edge
    apb(1'b1, 1, 16'h0001);
    ext_pin <= 5'h03;
    repeat (2) @(posedge pclk);
    ext_pin <= 5'h00;
    repeat (2) @(posedge pclk);
    rdchk(2, 32'h0001);
    rdchk(3, 32'h0010);
    apb(1'b1, 2, 16'h0000);
    apb(1'b1, 3, 16'h0000);
    // random user requests against a random cpu level and table choice
    for (i = 0; i < 40; i++) begin
      n = {$random(seed)} % 72;
      p = {$random(seed)} % 7 + 1;
      lvl = {$random(seed)} % 8;
      alt = {$random(seed)} % 2;
      apb(1'b1, 31, 16'(lvl << 5));
      apb(1'b1, 1, 16'(alt << 15));
      apb(1'b1, 7 + n / 16, 16'(1 << (n % 16)));
      apb(1'b1, 12 + n / 4, 16'(p << (4 * (n % 4))));
      pulse(72'h1 << n, 5'h00);
      chk(irq_req, impl(n) && p > lvl);
      if (impl(n) && p > lvl) begin
        chk(irq_vector_num, n + 8);
        chk(irq_level, p);
        chk(irq_vector_addr, vaddr(n + 8, alt));
        rdchk(30, (p << 8) | (n + 8));
      end
      apb(1'b0, 2 + n / 16, 16'h0);
      chk(rd[n % 16], impl(n));
      apb(1'b1, 2 + n / 16, 16'h0000);
      rdchk(2 + n / 16, 32'h0);
      apb(1'b1, 7 + n / 16, 16'h0000);
      apb(1'b1, 12 + n / 4, 16'h0000);
    end
    apb(1'b1, 31, 16'h0000);
    apb(1'b1, 1, 16'h0000);
    // equal levels go to the lower number, a higher level wins outright
    apb(1'b1, 12, 16'h4400);
    apb(1'b1, 7, 16'h000c);
    pulse(72'hc, 5'h00);
    chk(irq_vector_num, 10);
    apb(1'b1, 12, 16'h5400);
    repeat (2) @(posedge pclk);
    chk(irq_vector_num, 11);
    // ack with nesting allowed, then with nesting disabled
    for (i = 0; i < 2; i++) begin
      apb(1'b1, 0, 16'(i << 15));
      dly <= 4'(i * 5);
      take_ack();
      rdchk(31, i ? 32'h00e0 : 32'h00a0);
      repeat (20) @(posedge pclk);
    end
    apb(1'b1, 0, 16'h0000);
    apb(1'b1, 2, 16'h0000);
    apb(1'b1, 7, 16'h0000);
    // each trap source on its own entry and level
    for (i = 0; i < 5; i++) begin
      pulse(72'h0, 5'(1 << i));
      chk(irq_vector_num, i + 1);
      chk(irq_level, 14 - i);
      chk(irq_vector_addr, vaddr(i + 1, 0));
      apb(1'b1, 0, 16'h0000);
    end
    // a taken trap raises the high level bit, which masks user requests
    ret_lvl <= 4'h8;
    pulse(72'h0, 5'h01);
    take_ack();
    rdchk(32, 32'h0008);
    apb(1'b1, 0, 16'h0000);
    repeat (20) @(posedge pclk);
    apb(1'b1, 12, 16'h0070);
    apb(1'b1, 7, 16'h0002);
    pulse(72'h2, 5'h00);
    chk(irq_req, 1'b0);
    apb(1'b1, 32, 16'h0000);
    repeat (2) @(posedge pclk);
    chk(irq_vector_num, 9);
    wrap_up();
  end
endmodule : tb_vectored_priority_interrupt_ctrl

`default_nettype wire
